/* File: design/ipr_regs.vh */
// Purpose: Register map, field positions and reset values of the priority register bank.
// Assumes: APB byte addresses, one aligned 32-bit word per 16-bit register.
// Notes:   Offsets are local choices; no offset is printed for these registers.
`ifndef IPR_REGS_VH
`define IPR_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define IPR_OFS_CAP78_EXT1      12'h000
`define IPR_OFS_TMR4_CMP34      12'h004
`define IPR_OFS_SER2_EXT2_TMR5  12'h008
`define IPR_OFS_SPI2            12'h00C
`define IPR_OFS_CAP345          12'h010
`define IPR_OFS_PENDING         12'h014
`define IPR_OFS_CPU_LEVEL       12'h018
`define IPR_OFS_REQUEST         12'h01C

// ----------------------------------------------------------------------------
// Field positions (low bit of each 3-bit field)
// ----------------------------------------------------------------------------
`define IPR_POS_HI              12
`define IPR_POS_MID             8
`define IPR_POS_LO_HI           4
`define IPR_POS_LO              0

// ----------------------------------------------------------------------------
// Implemented-bit masks and reset values
// ----------------------------------------------------------------------------
`define IPR_MASK_CAP78_EXT1     16'h7707
`define IPR_MASK_TMR4_CMP34     16'h7770
`define IPR_MASK_SER2_EXT2_TMR5 16'h7777
`define IPR_MASK_SPI2           16'h0077
`define IPR_MASK_CAP345         16'h7770
`define IPR_RST_FIELD           3'h4
`define IPR_RST_ALL             16'h4444
`define IPR_NUM_SRC             15
`define IPR_LVL_OFF             3'h0

`endif

/* File: design/ipr_field.v */
// Purpose: One masked 16-bit priority register with write filtering.
// Assumes: Write strobe is a single-cycle pulse from the bus slave.
// Notes:   Unimplemented bits hold zero permanently.
`timescale 1ns/1ps
`include "ipr_regs.vh"

module ipr_field #(
    parameter [15:0] MASK = 16'hFFFF
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        wr_en,
    input  wire [15:0] wr_data,
    output wire [15:0] value
);
    reg [15:0] reg_q;

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_q <= `IPR_RST_ALL & MASK;
        end else if (wr_en) begin
            reg_q <= wr_data & MASK;
        end
    end

    assign value = reg_q;
endmodule // ipr_field

/* File: design/ipr_rank.v */
// Purpose: Ranks pending sources by their priority level.
// Assumes: All inputs are synchronous to pclk.
// Notes:   Ties go to the lowest source index.
`timescale 1ns/1ps
`include "ipr_regs.vh"

module ipr_rank (
    input  wire [44:0] levels,
    input  wire [14:0] pending,
    input  wire [2:0]  cpu_level,
    output reg         req,
    output reg  [3:0]  req_src,
    output reg  [2:0]  req_level
);
    integer i;
    reg [2:0] lv;

    // ------------------------------------------------------------------------
    // Highest level wins, strictly above the processor's level
    // ------------------------------------------------------------------------
    always @* begin
        req       = 1'b0;
        req_src   = 4'h0;
        req_level = `IPR_LVL_OFF;
        lv        = 3'h0;
        for (i = 0; i < `IPR_NUM_SRC; i = i + 1) begin
            lv = levels[i*3 +: 3];
            // A zero level never competes, whatever the pending state.
            if (pending[i] && lv != `IPR_LVL_OFF && lv > req_level) begin
                req       = 1'b1;
                req_src   = i[3:0];
                req_level = lv;
            end
        end
        // A suppressed winner shows no source and no level, so idle outputs stay all zero.
        if (req_level <= cpu_level) begin
            req       = 1'b0;
            req_src   = 4'h0;
            req_level = `IPR_LVL_OFF;
        end
    end
endmodule // ipr_rank

/* File: design/ipr_top.v */
// Purpose: APB-reached bank of interrupt priority registers and request ranking.
// Assumes: Pending inputs are already flag-and-enable qualified and synchronous.
// Notes:   Slave answers with zero wait states; unmapped reads return zero.
//
// Summary of operation
// - Code seven is the highest priority level.
// - Code one lowest; codes rank in order.
// - Code zero disables the source completely.
// - Unassigned bits read zero, ignore writes.
// - Every field resets to level four.
// - SPI2 event priority sits in bits 6-4.
// - SPI2 fault priority sits in bits 2-0.
// - Compare three priority sits in bits 6-4.
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "ipr_regs.vh"

module ipr_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [14:0] src_pending,
    input  wire [2:0]  cpu_level,
    output reg         irq_req,
    output reg  [3:0]  irq_src,
    output reg  [2:0]  irq_level
);
    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    wire        wr_acc;
    wire [15:0] wdata16;
    wire [15:0] r0;
    wire [15:0] r1;
    wire [15:0] r2;
    wire [15:0] r3;
    wire [15:0] r4;
    reg  [31:0] rd_d;
    reg         hit_d;
    wire [44:0] levels;
    wire        rk_req;
    wire [3:0]  rk_src;
    wire [2:0]  rk_level;

    function wr_sel;
        input [11:0] a;
        input [11:0] ofs;
        begin
            wr_sel = (a == ofs);
        end
    endfunction

    // A write lands only at the edge that completes the access phase with pready high.
    assign wr_acc  = psel && penable && pready && pwrite;
    // Both low lanes must be strobed; a partial write is dropped whole.
    assign wdata16 = pwdata[15:0];

    // ------------------------------------------------------------------------
    // Priority registers
    // ------------------------------------------------------------------------
    // Each register sees the same unmasked write data; its own enable and its MASK differ.
    ipr_field #(.MASK(`IPR_MASK_CAP78_EXT1)) u_r0 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_acc && wr_sel(paddr, `IPR_OFS_CAP78_EXT1) && pstrb[1:0] == 2'h3),
        .wr_data (wdata16),
        .value   (r0)
    );
    ipr_field #(.MASK(`IPR_MASK_TMR4_CMP34)) u_r1 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_acc && wr_sel(paddr, `IPR_OFS_TMR4_CMP34) && pstrb[1:0] == 2'h3),
        .wr_data (wdata16),
        .value   (r1)
    );
    ipr_field #(.MASK(`IPR_MASK_SER2_EXT2_TMR5)) u_r2 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_acc && wr_sel(paddr, `IPR_OFS_SER2_EXT2_TMR5) && pstrb[1:0] == 2'h3),
        .wr_data (wdata16),
        .value   (r2)
    );
    ipr_field #(.MASK(`IPR_MASK_SPI2)) u_r3 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_acc && wr_sel(paddr, `IPR_OFS_SPI2) && pstrb[1:0] == 2'h3),
        .wr_data (wdata16),
        .value   (r3)
    );
    ipr_field #(.MASK(`IPR_MASK_CAP345)) u_r4 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_acc && wr_sel(paddr, `IPR_OFS_CAP345) && pstrb[1:0] == 2'h3),
        .wr_data (wdata16),
        .value   (r4)
    );

    // ------------------------------------------------------------------------
    // Source level vector, index order fixed for the pending inputs
    // ------------------------------------------------------------------------
    assign levels = {
        r4[`IPR_POS_LO_HI +: 3],   // 14 capture3
        r4[`IPR_POS_MID +: 3],     // 13 capture4
        r4[`IPR_POS_HI +: 3],      // 12 capture5
        r3[`IPR_POS_LO +: 3],      // 11 spi2 fault
        r3[`IPR_POS_LO_HI +: 3],   // 10 spi2 event
        r2[`IPR_POS_LO +: 3],      // 9 timer5
        r2[`IPR_POS_LO_HI +: 3],   // 8 ext pin2
        r2[`IPR_POS_MID +: 3],     // 7 serial2 receive
        r2[`IPR_POS_HI +: 3],      // 6 serial2 transmit
        r1[`IPR_POS_LO_HI +: 3],   // 5 compare3
        r1[`IPR_POS_MID +: 3],     // 4 compare4
        r1[`IPR_POS_HI +: 3],      // 3 timer4
        r0[`IPR_POS_LO +: 3],      // 2 ext pin1
        r0[`IPR_POS_MID +: 3],     // 1 capture7
        r0[`IPR_POS_HI +: 3]       // 0 capture8
    };

    ipr_rank u_rank (
        .levels    (levels),
        .pending   (src_pending),
        .cpu_level (cpu_level),
        .req       (rk_req),
        .req_src   (rk_src),
        .req_level (rk_level)
    );

    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------
    always @* begin
        rd_d  = 32'h00000000;
        hit_d = 1'b1;
        case (paddr)
            `IPR_OFS_CAP78_EXT1:     rd_d = {16'h0000, r0};
            `IPR_OFS_TMR4_CMP34:     rd_d = {16'h0000, r1};
            `IPR_OFS_SER2_EXT2_TMR5: rd_d = {16'h0000, r2};
            `IPR_OFS_SPI2:           rd_d = {16'h0000, r3};
            `IPR_OFS_CAP345:         rd_d = {16'h0000, r4};
            `IPR_OFS_PENDING:        rd_d = {17'h00000, src_pending};
            `IPR_OFS_CPU_LEVEL:      rd_d = {29'h00000000, cpu_level};
            `IPR_OFS_REQUEST:        rd_d = {24'h000000, irq_req, irq_src, irq_level};
            default: begin
                hit_d = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // APB answer and registered request outputs
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata    <= 32'h00000000;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            irq_req   <= 1'b0;
            irq_src   <= 4'h0;
            irq_level <= 3'h0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit_d;
            if (psel && !penable && !pwrite) begin
                prdata <= rd_d;
            end
            irq_req   <= rk_req;
            irq_src   <= rk_src;
            irq_level <= rk_level;
        end
    end
endmodule // ipr_top

/* File: tb/ipr_top_sva.sv */
// Purpose: Port checks for the priority bank: bus timing, layout, ranking.
// Assumes: One clock, reset asynchronous and active low.
// Notes:   Layout checks look only at reads of fixed offsets.
`timescale 1ns/1ps
`include "ipr_regs.vh"
module ipr_top_sva (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [14:0] src_pending,
    input wire [2:0]  cpu_level,
    input wire        irq_req,
    input wire [3:0]  irq_src,
    input wire [2:0]  irq_level
);
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_unmapped: assert property (pready
        |-> pslverr == (paddr > 12'h01F || paddr[1:0] != 2'h0))
        else $error("pslverr wrong for address");
    a_spi2_layout: assert property (pready && !pwrite && paddr == `IPR_OFS_SPI2
        |-> (prdata & 32'hFFFFFF88) == 32'h0)
        else $error("spare bits set in spi2 register");
    a_ext1_layout: assert property (pready && !pwrite && paddr == `IPR_OFS_CAP78_EXT1
        |-> (prdata & 32'hFFFF88F8) == 32'h0)
        else $error("spare bits set in capture register");
    a_cmp3_layout: assert property (pready && !pwrite && paddr == `IPR_OFS_TMR4_CMP34
        |-> (prdata & 32'hFFFF888F) == 32'h0)
        else $error("spare bits set in timer register");
    a_irq_above: assert property (irq_req |-> irq_level > $past(cpu_level))
        else $error("request not above processor level");
    a_irq_nonzero: assert property (irq_req |-> irq_level != 3'h0)
        else $error("request at disabled level");
    a_irq_pending: assert property (irq_req
        |-> (($past(src_pending) >> irq_src) & 15'h0001) != 15'h0)
        else $error("request from idle source");
    a_quiet_idle: assert property ($past(src_pending) == 15'h0 |-> !irq_req)
        else $error("request with nothing pending");
    a_irq_idle_zero: assert property (!irq_req |-> irq_src == 4'h0 && irq_level == 3'h0)
        else $error("source or level shown without request");
endmodule // ipr_top_sva

bind ipr_top ipr_top_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_pending(src_pending),
    .cpu_level(cpu_level), .irq_req(irq_req), .irq_src(irq_src), .irq_level(irq_level));

/* File: tb/ipr_tb_top.sv */
// Purpose: Self-checking bench for the priority register bank.
// Assumes: Zero-wait APB slave; ranking lags inputs by one cycle.
// Notes:   Waits on pready have no fixed count; a cycle ceiling cuts hangs.
`timescale 1ns/1ps
`include "ipr_regs.vh"
module ipr_tb_top;
    // ------------------------------------------------------------------
    // Stimulus and checks
    // ------------------------------------------------------------------
    reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg  [11:0] paddr = 12'h0;
    reg  [31:0] pwdata = 32'h0;
    reg  [3:0]  pstrb = 4'h0;
    reg  [14:0] src_pending = 15'h0;
    reg  [2:0]  cpu_level = 3'h0;
    wire [31:0] prdata;
    wire        pready, pslverr, irq_req;
    wire [3:0]  irq_src;
    wire [2:0]  irq_level;
    int         errors = 0, n_tests = 0, cyc = 0;
    logic [11:0] ofs [5] = '{`IPR_OFS_CAP78_EXT1, `IPR_OFS_TMR4_CMP34,
        `IPR_OFS_SER2_EXT2_TMR5, `IPR_OFS_SPI2, `IPR_OFS_CAP345};
    logic [15:0] msk [5] = '{`IPR_MASK_CAP78_EXT1, `IPR_MASK_TMR4_CMP34,
        `IPR_MASK_SER2_EXT2_TMR5, `IPR_MASK_SPI2, `IPR_MASK_CAP345};

    ipr_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src_pending(src_pending),
        .cpu_level(cpu_level), .irq_req(irq_req), .irq_src(irq_src), .irq_level(irq_level));

    always #12.5 pclk = ~pclk;

    task end_of_test;
        if (errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // A ceiling well above the two hundred or so cycles the scenarios need.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            end_of_test();
        end
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask

    // For a read, d is the expected data; ee is the expected error flag in both directions.
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
              input logic ee);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= w ? d : 32'h0;
        pstrb   <= w ? s : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        if (!w) chk("prdata", d, prdata);
        chk("pslverr", {31'h0, ee}, {31'h0, pslverr});
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
        xfer(1'b0, a, e, 4'h0, ee);
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        xfer(1'b1, a, d, s, 1'b0);
    endtask

    task irq_chk(input logic q, input logic [3:0] s, input logic [2:0] l);
        repeat (2) @(posedge pclk);
        chk("irq", {24'h0, q, s, l}, {24'h0, irq_req, irq_src, irq_level});
    endtask

    task t_reset;
        for (int i = 0; i < 5; i++) rd(ofs[i], {16'h0, `IPR_RST_ALL & msk[i]}, 1'b0);
    endtask

    task t_fields;
        for (int i = 0; i < 5; i++) begin
            wr(ofs[i], 32'hFFFFFFFF, 4'hF);
            rd(ofs[i], {16'h0, msk[i]}, 1'b0);
            wr(ofs[i], 32'h0, 4'h1);
            rd(ofs[i], {16'h0, msk[i]}, 1'b0);
            wr(ofs[i], 32'h0, 4'hF);
            rd(ofs[i], 32'h0, 1'b0);
        end
        xfer(1'b1, 12'h100, 32'hFFFFFFFF, 4'hF, 1'b1);
        rd(12'h100, 32'h0, 1'b1);
    endtask

    task t_rank;
        src_pending <= 15'h7FFF;
        irq_chk(1'b0, 4'h0, 3'h0);
        src_pending <= 15'h0C00;
        for (int c = 1; c < 8; c++) begin
            cpu_level <= 3'h0;
            wr(`IPR_OFS_SPI2, {25'h0, c[2:0], 1'b0, c[2:0] - 3'h1}, 4'hF);
            irq_chk(1'b1, 4'hA, c[2:0]);
            cpu_level <= c[2:0];
            irq_chk(1'b0, 4'h0, 3'h0);
        end
        cpu_level <= 3'h2;
        wr(`IPR_OFS_SPI2, 32'h33, 4'hF);
        irq_chk(1'b1, 4'hA, 3'h3);
        src_pending <= 15'h0820;
        wr(`IPR_OFS_TMR4_CMP34, 32'h70, 4'hF);
        irq_chk(1'b1, 4'h5, 3'h7);
        src_pending <= 15'h0800;
        irq_chk(1'b1, 4'hB, 3'h3);
        wr(`IPR_OFS_CPU_LEVEL, 32'h7, 4'hF);
        rd(`IPR_OFS_CPU_LEVEL, 32'h2, 1'b0);
        rd(`IPR_OFS_PENDING, 32'h0800, 1'b0);
        rd(`IPR_OFS_REQUEST, {24'h0, 1'b1, 4'hB, 3'h3}, 1'b0);
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_fields();
        t_rank();
        end_of_test();
    end
endmodule // ipr_tb_top
